// ===== hdl/resolver_position_output_interface.sv
`timescale 1ns/1ns
`include "resolver_out_cfg.svh"
// Function
// - the parallel position word is always the full twelve bits wide.
// - the serial word is latched half a parallel update period apart.
// - serial and parallel values read together may differ by one step.
// - pulses on the data pins equal those on the dedicated pulse pins.
// - both pulse outputs are driven at the same time.
// - pulse duty follows the angle samples and is not made uniform.
// - each output works alone with the others unused.
// - serial data is undefined from select fall to first clock fall.
// - a new serial bit is presented on each shift clock falling edge.

// small first-in first-out buffer for position samples
module sample_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // handshakes on both sides
  // full when the fill level reaches the depth, empty at zero
  // count is one bit wider than the pointers so full and empty differ
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  // storage write
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // pointers and fill level
  // pointers wrap at the depth, so a depth that is not a power of two
  // still walks every slot; push and pop together keep the level
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

// output interface: parallel word, serial shift port, quadrature pulses
module resolver_position_output_interface
  import resolver_out_pkg::*;
#(
  parameter int          POS_W      = `POS_WIDTH,
  parameter logic [15:0] UPD_CYCLES = `UPDATE_CYCLES
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  input  wire resolver_out_pkg::sample_t sample_i,
  input  wire logic                 sample_valid_i,
  output logic                      sample_ready_o,
  input  wire logic                 pulse_mode_i,
  input  wire logic                 serial_select_n_i,
  input  wire logic                 shift_clk_i,
  output logic [POS_W-1:0]          par_data_o,
  output logic                      serial_data_o,
  output logic                      serial_data_oe_n_o,
  output logic                      pulse_a_o,
  output logic                      pulse_b_o,
  output logic                      pulse_z_o
);
  import resolver_out_pkg::*;

  // buffered sample path
  sample_t     fifo_data;
  logic        fifo_valid;
  logic        fifo_ready;
  sample_t     current;
  logic [2:0]  pulse_now;
  logic [2:0]  pulse_q;

  // update timing
  logic [15:0] phase;
  logic        par_tick;
  logic        ser_tick;

  // serial path
  logic [11:0] ser_latch;
  logic [11:0] shift_reg;

  // pin synchronisers and their edges
  logic [2:0]  sel_sync;
  logic [2:0]  sck_sync;
  logic        sck_fall;
  logic        sel_fall;
  logic        selected;

  // falling edge between the second and third synchroniser stages
  // the first stage is never read by logic, only by the next stage
  function automatic logic fell_edge(input logic [2:0] taps);
    fell_edge = taps[2] && !taps[1];
  endfunction : fell_edge

  // incoming samples buffered; drained one per core cycle
  sample_fifo #(
    .WIDTH ($bits(sample_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (),
    .in_data_i   (sample_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_ready),
    .out_data_o  (fifo_data)
  );

  // drain side always takes a word, so the buffer never fills
  assign fifo_ready = 1'b1;

  // ready toward source, low in reset and until the first clock edge after it
  // taken from a flip-flop so the pin never glitches
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sample_ready_o <= 1'b0;
    else
      sample_ready_o <= 1'b1;
  end

  // track latest angle sample
  // one word per cycle leaves the buffer, newest wins
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      current <= '0;
    else if (fifo_valid)
      current <= fifo_data;
  end

  // update phase counter; serial tick at half period
  // parallel tick at phase zero, serial tick half a period later
  // the offset is why serial and parallel may differ by one step
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      phase <= '0;
    else if (phase == UPD_CYCLES - 16'h0001)
      phase <= '0;
    else
      phase <= phase + 16'h0001;
  end

  // latch instants of the two outputs
  assign par_tick = (phase == 16'h0000);
  assign ser_tick = (phase == (UPD_CYCLES >> 1));

  // pulse bits of the latest sample, a b z order
  assign pulse_now = {current.pulse_a, current.pulse_b, current.pulse_z};

  // parallel word or pulses on the data pins
  // pulse mode follows every sample; word mode waits for its tick
  // a host wanting fewer bits keeps the upper part of the word
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      par_data_o <= '0;
    else if (pulse_mode_i)
      par_data_o <= {{(POS_W-3){1'b0}}, pulse_now};
    else if (par_tick)
      par_data_o <= current.angle;
  end

  // dedicated pulse pins from the same source, raw duty
  // same flip-flop stage as the data pins, so both show one value
  // duty is not smoothed; it follows the samples as they come
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pulse
      always_ff @(posedge core_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          pulse_q[gi] <= 1'b0;
        else
          pulse_q[gi] <= pulse_now[gi];
      end
    end
  endgenerate

  // pins straight from the pulse flip-flops
  assign pulse_a_o = pulse_q[2];
  assign pulse_b_o = pulse_q[1];
  assign pulse_z_o = pulse_q[0];

  // serial latch at its own instant
  // reloaded each period, even while a word is shifted out
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ser_latch <= '0;
    else if (ser_tick)
      ser_latch <= current.angle;
  end

  // synchronisers for select and shift clock
  // reset to the idle high level so no false edge follows reset
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sel_sync <= 3'b111;
      sck_sync <= 3'b111;
    end
    else
    begin
      sel_sync <= {sel_sync[1:0], serial_select_n_i};
      sck_sync <= {sck_sync[1:0], shift_clk_i};
    end
  end

  // edges and level seen on the core clock
  assign sck_fall = fell_edge(sck_sync);
  assign sel_fall = fell_edge(sel_sync);
  assign selected = !sel_sync[1];

  // shift register: load on select fall, shift on clock fall
  // msb leaves first; clocks past the word shift in zeros
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      shift_reg <= '0;
    else if (sel_fall)
      shift_reg <= ser_latch;
    else if (selected && sck_fall)
      shift_reg <= {shift_reg[10:0], 1'b0};
  end

  // data pin: undefined until first clock fall, then msb first
  // bit changes a few core cycles after the clock fall, well
  // before the host samples on the following rise
  // driver enabled only while selected, released otherwise
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      serial_data_o      <= 1'b0;
      serial_data_oe_n_o <= 1'b1;
    end
    else
    begin
      serial_data_oe_n_o <= !selected;
      if (sel_fall)
        serial_data_o <= 1'b0;
      else if (selected && sck_fall)
        serial_data_o <= shift_reg[11];
    end
  end
endmodule : resolver_position_output_interface

// ===== hdl/resolver_out_cfg.svh
`ifndef RESOLVER_OUT_CFG_SVH
`define RESOLVER_OUT_CFG_SVH
// position word width
`define POS_WIDTH 12
// internal latch period in core cycles
`define UPDATE_CYCLES 16'h0010
// fifo depth
`define FIFO_DEPTH 8
`endif

// ===== hdl/resolver_out_pkg.sv
package resolver_out_pkg;
  // one position sample with its quadrature state
  typedef struct packed {
    logic [11:0] angle;
    logic        pulse_a;
    logic        pulse_b;
    logic        pulse_z;
  } sample_t;
endpackage : resolver_out_pkg

// ===== verification/rpo_props.sv
`timescale 1ns/1ns
// port relations of the output interface
module rpo_props
  import resolver_out_pkg::*;
#(parameter int POS_W = 12) (
  input wire logic             core_clk_i,
  input wire logic             resetn_i,
  input wire sample_t          sample_i,
  input wire logic             sample_valid_i,
  input wire logic             sample_ready_o,
  input wire logic             pulse_mode_i,
  input wire logic             serial_select_n_i,
  input wire logic             shift_clk_i,
  input wire logic [POS_W-1:0] par_data_o,
  input wire logic             serial_data_o,
  input wire logic             serial_data_oe_n_o,
  input wire logic             pulse_a_o,
  input wire logic             pulse_b_o,
  input wire logic             pulse_z_o
);
  // core clock, quiet in reset
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire [2:0] pls = {pulse_a_o, pulse_b_o, pulse_z_o};
  // properties
  property p_rdy; $past(resetn_i) |-> sample_ready_o; endproperty
  property p_par; !pulse_mode_i && $changed(par_data_o)
    |=> ($stable(par_data_o) || pulse_mode_i)[*8]; endproperty
  property p_pm; pulse_mode_i && $past(pulse_mode_i, 3)
    |-> par_data_o == POS_W'(pls); endproperty
  property p_pls; !sample_valid_i[*4] |=> $stable(pls); endproperty
  property p_off; serial_select_n_i[*6] |-> serial_data_oe_n_o; endproperty
  property p_on; !serial_select_n_i[*6] |-> !serial_data_oe_n_o; endproperty
  property p_fall; $fell(serial_select_n_i)
    |-> ##[2:5] !serial_data_oe_n_o; endproperty
  property p_shf; $rose(shift_clk_i) && !serial_select_n_i
    |=> $stable(serial_data_o)[*3]; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  a_par: assert property (p_par) else $error("par early");
  a_pm: assert property (p_pm) else $error("pulse pins");
  a_pls: assert property (p_pls) else $error("pulse drift");
  a_off: assert property (p_off) else $error("oe stuck");
  a_on: assert property (p_on) else $error("oe high");
  a_fall: assert property (p_fall) else $error("oe late");
  a_shf: assert property (p_shf) else $error("bit moved");
  c_rd: cover property ($fell(serial_select_n_i));
  c_pm: cover property (pulse_mode_i && sample_valid_i);
  c_idle: cover property (!sample_valid_i[*4]);
endmodule : rpo_props
bind resolver_position_output_interface rpo_props #(.POS_W(POS_W)) u_p (.*);

// ===== verification/rpo_host.sv
`timescale 1ns/1ns
// host reading the serial position word
module rpo_host (
  output logic      serial_select_n_o,
  output logic      shift_clk_o,
  input  wire logic serial_data_i,
  input  wire logic serial_data_oe_n_i
);
  // released line shows the inverse of its level
  task automatic read_word(output logic [11:0] w);
    serial_select_n_o = 1'b0;
    #230;
    repeat (12)
    begin
      shift_clk_o = 1'b0;
      #200;
      shift_clk_o = 1'b1;
      w = {w[10:0], serial_data_i ^ serial_data_oe_n_i};
      #200;
    end
    serial_select_n_o = 1'b1;
    #400;
  endtask : read_word
  // idle levels
  initial
  begin
    serial_select_n_o = 1'b1;
    shift_clk_o = 1'b1;
  end
endmodule : rpo_host

// ===== verification/resolver_position_output_interface_tb_top.sv
`timescale 1ns/1ns
module resolver_position_output_interface_tb_top;
  import resolver_out_pkg::*;
  logic        core_clk_i = 1'b0, resetn_i = 1'b0;
  logic        sample_valid_i = 1'b0, pulse_mode_i = 1'b0;
  sample_t     sample_i = '0;
  logic        serial_select_n_i, shift_clk_i, sample_ready_o;
  logic        serial_data_o, serial_data_oe_n_o;
  logic        pulse_a_o, pulse_b_o, pulse_z_o;
  logic [11:0] par_data_o, w, par, ang;
  logic [11:0] exp_q[$];
  int          n_errors = 0, n_checks = 0, cyc = 0, seed = 32'hac44;
  event        got;
  // core clock
  always #25 core_clk_i = ~core_clk_i;
  resolver_position_output_interface dut (.*);
  rpo_host host (
    .serial_select_n_o (serial_select_n_i),
    .shift_clk_o       (shift_clk_i),
    .serial_data_i     (serial_data_o),
    .serial_data_oe_n_i(serial_data_oe_n_o)
  );
  // compare and count
  task automatic chk(input logic [11:0] got_v, input logic [11:0] exp_v);
    n_checks++;
    if (got_v !== exp_v)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got_v, exp_v);
    end
  endtask : chk
  // report and stop
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // offer one sample for n cycles, valid mostly high
  task automatic hold(input logic [11:0] a, input logic [2:0] p, input int n);
    repeat (n)
    begin
      @(negedge core_clk_i);
      sample_i = {a, p};
      sample_valid_i = ($random(seed) % 4) != 0;
    end
  endtask : hold
  // hang limit
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end
  // serial words against the oldest note
  always @(got)
    chk(w, exp_q.pop_front());
  // stimulus
  initial
  begin
    repeat (6) @(negedge core_clk_i);
    resetn_i = 1'b1;
    repeat (3)
    begin
      ang = $random(seed);
      hold(ang, ang[2:0], 40);
      @(negedge core_clk_i);
      sample_valid_i = 1'b0;
      chk(par_data_o, ang);
      chk({4'h0, par_data_o[11:4]}, {4'h0, ang[11:4]});
      chk({9'h0, pulse_a_o, pulse_b_o, pulse_z_o}, {9'h0, ang[2:0]});
      exp_q.push_back(ang);
      host.read_word(w);
      ->got;
    end
    fork
      for (int i = 1; i < 40; i++) hold(ang + i[11:0], 3'h0, 8);
      begin
        #1000;
        par = par_data_o;
        host.read_word(w);
      end
    join
    chk(12'((w - par + 12'h1) <= 12'h2), 12'h1);
    @(negedge core_clk_i);
    pulse_mode_i = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      hold(ang, i[2:0], 20);
      chk(par_data_o, {9'h0, i[2:0]});
    end
    end_sim();
  end
endmodule : resolver_position_output_interface_tb_top
